// file: hdl/glk_guard_lock.sv
// What this block does
// RULE_01: Power-to-unlock build: active command unlocks, inactive command keeps it locked.
// RULE_02: Power-to-lock build: active command locks, inactive command releases.
// RULE_03: Lock-monitoring variant: outputs off when unlocked, on only closed and locked.
// RULE_04: Lock-monitoring variant: relocking with actuator inserted re-enables outputs directly.
// RULE_05: Position-monitoring variant: outputs off only when guard open.
// RULE_06: Green shows supply, yellow shows condition, red shows errors and warnings.
// RULE_07: Chain input missing: green flashes, red off, yellow by guard state, outputs off.
// RULE_08: Diagnostic high only closed and lockable or locked, with no error or warning.
// RULE_09: Internal error drops safety and diagnostic outputs at once, red lamp shows it.
// RULE_10: Latched error clears only after cause gone and guard opened then closed.
// RULE_11: Fault warning drops diagnostic output but keeps safety outputs enabled.
// RULE_12: Fault warning clears by itself once its cause disappears.
// RULE_13: Warning lasting thirty minutes escalates to fault, outputs off, red flashes.
// RULE_14: Output one test fault or foreign voltage: delayed warning, one red pulse.
// RULE_15: Output two test fault or foreign voltage: delayed warning, two red pulses.
// RULE_16: Cross short or both outputs faulty: delayed warning, three red pulses.
// RULE_17: Excess internal temperature: delayed warning, four red pulses.
// RULE_18: Wrong or defective actuator or broken bracket: immediate fault, five pulses.
// RULE_19: Adjuster in non-permitted position: immediate fault, six red pulses.
// RULE_20: Recodable variant: after new code learned, ten-minute inhibit, green flashes.
// RULE_21: Red pulse groups repeat with longer pause; internal defect shows steady red.
`timescale 1ns/1ns
`default_nettype none

module glk_guard_lock #(
    parameter longint unsigned WARN_CYCLES    = glk_pkg::WARN_CYC,
    parameter longint unsigned INHIBIT_CYCLES = glk_pkg::INHIBIT_CYC,
    parameter int unsigned     HALF_CYCLES    = glk_pkg::FLASH_HALF_CYC,
    parameter int unsigned     PULSE_CYCLES   = glk_pkg::PULSE_CYC
) (
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic power_to_lock,
    input  wire logic position_variant,
    input  wire logic recodable_coding,
    input  wire logic one_time_coding,
    input  wire logic lock_cmd,
    input  wire logic chain_input_one,
    input  wire logic chain_input_two,
    input  wire logic guard_closed,
    input  wire logic actuator_locked,
    input  wire logic lock_possible,
    input  wire logic code_learned,
    input  wire logic fault_out1,
    input  wire logic fault_out2,
    input  wire logic fault_cross,
    input  wire logic fault_temp,
    input  wire logic fault_actuator,
    input  wire logic fault_knob,
    input  wire logic fault_internal,
    output logic      solenoid_lock,
    output logic      safe_output_one,
    output logic      safe_output_two,
    output logic      diag_out,
    output logic      led_green,
    output logic      led_yellow,
    output logic      led_red
);

    localparam int NIN = 17;

    // Two-stage synchronisers for all pins except one_time_coding, which is not used
    logic [NIN-1:0] pin_raw;
    logic [NIN-1:0] sync_a;
    logic [NIN-1:0] sync_b;

    assign pin_raw = {lock_cmd, chain_input_one, chain_input_two, guard_closed,
                      actuator_locked, lock_possible, code_learned, fault_out1,
                      fault_out2, fault_cross, fault_temp, fault_actuator,
                      fault_knob, fault_internal, power_to_lock, position_variant,
                      recodable_coding};

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= pin_raw;
            sync_b <= sync_a;
        end
    end

    logic s_cmd, s_x1, s_x2, s_closed, s_locked, s_lockable, s_learned;
    logic s_f1, s_f2, s_fx, s_ft, s_fa, s_fk, s_fi, s_ptl, s_pos, s_reco;
    assign {s_cmd, s_x1, s_x2, s_closed, s_locked, s_lockable, s_learned, s_f1,
            s_f2, s_fx, s_ft, s_fa, s_fk, s_fi, s_ptl, s_pos, s_reco} = sync_b;

    // Solenoid drive decode
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            solenoid_lock <= 1'b0;
        end else if (s_ptl) begin
            solenoid_lock <= s_cmd;                                 // [RULE_02]
        end else begin
            solenoid_lock <= !s_cmd;                                // [RULE_01]
        end
    end

    // Guard state
    glk_pkg::glk_guard_e guard;
    always_comb begin
        if (!s_closed) begin
            guard = glk_pkg::GLK_OPEN;
        end else if (s_locked) begin
            guard = glk_pkg::GLK_LOCKED;
        end else begin
            guard = glk_pkg::GLK_CLOSED;
        end
    end

    logic chain_ok;
    assign chain_ok = s_x1 && s_x2;

    // Warning and its escalation timer
    logic            warn_any;
    logic            warn_fault;
    longint unsigned warn_cnt;
    assign warn_any = s_f1 || s_f2 || s_fx || s_ft;                 // [RULE_12]

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            warn_cnt <= '0;
        end else if (!warn_any) begin
            warn_cnt <= '0;                                         // [RULE_12]
        end else if (warn_cnt < WARN_CYCLES) begin
            warn_cnt <= warn_cnt + 64'h1;                           // [RULE_13]
        end
    end
    assign warn_fault = warn_any && (warn_cnt >= WARN_CYCLES);      // [RULE_13]

    // Latched error, cleared by open then close after cause gone
    logic err_latch;
    logic err_seen_open;
    logic err_cause;
    assign err_cause = s_fa || s_fk || s_fi || warn_fault;          // [RULE_18] [RULE_19]

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            err_latch     <= 1'b0;
            err_seen_open <= 1'b0;
        end else if (err_cause) begin
            err_latch     <= 1'b1;                                  // [RULE_09]
            err_seen_open <= 1'b0;
        end else if (err_latch && !s_closed) begin
            err_seen_open <= 1'b1;                                  // [RULE_10]
        end else if (err_latch && err_seen_open && s_closed) begin
            err_latch     <= 1'b0;                                  // [RULE_10]
            err_seen_open <= 1'b0;
        end
    end

    logic err_now;
    assign err_now = err_cause || err_latch;

    // Enabling inhibit after recoding
    longint unsigned inh_cnt;
    logic            inhibit;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            inh_cnt <= '0;
        end else if (s_reco && s_learned) begin
            inh_cnt <= INHIBIT_CYCLES;                              // [RULE_20]
        end else if (inh_cnt != 64'h0) begin
            inh_cnt <= inh_cnt - 64'h1;
        end
    end
    assign inhibit = (inh_cnt != 64'h0);

    // Safety outputs and diagnostic output
    logic next_safe;
    logic next_diag;
    always_comb begin
        if (s_pos) begin
            next_safe = (guard != glk_pkg::GLK_OPEN);               // [RULE_05]
        end else begin
            next_safe = (guard == glk_pkg::GLK_LOCKED);             // [RULE_03] [RULE_04]
        end
        if (!chain_ok || err_now || inhibit) begin
            next_safe = 1'b0;                                       // [RULE_07] [RULE_09]
        end
        next_diag = s_closed && (s_locked || s_lockable)
                    && !err_now && !warn_any && !inhibit;           // [RULE_08] [RULE_11]
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            safe_output_one <= 1'b0;
            safe_output_two <= 1'b0;
            diag_out        <= 1'b0;
        end else begin
            safe_output_one <= next_safe;
            safe_output_two <= next_safe;
            diag_out        <= next_diag;
        end
    end

    // 1 Hz flash base
    logic [31:0] half_cnt;
    logic        blink;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            half_cnt <= '0;
            blink    <= 1'b0;
        end else if (half_cnt >= HALF_CYCLES - 1) begin
            half_cnt <= '0;
            blink    <= !blink;
        end else begin
            half_cnt <= half_cnt + 32'h1;
        end
    end

    // Red flash code selection, highest code wins
    logic [2:0] code;
    always_comb begin
        code = glk_pkg::CODE_NONE;
        if (s_f1) begin
            code = glk_pkg::CODE_OUT1;                              // [RULE_14]
        end
        if (s_f2) begin
            code = glk_pkg::CODE_OUT2;                              // [RULE_15]
        end
        if (s_fx || (s_f1 && s_f2)) begin
            code = glk_pkg::CODE_CROSS;                             // [RULE_16]
        end
        if (s_ft) begin
            code = glk_pkg::CODE_TEMP;                              // [RULE_17]
        end
        if (s_fa) begin
            code = glk_pkg::CODE_ACT;                               // [RULE_18]
        end
        if (s_fk) begin
            code = glk_pkg::CODE_KNOB;                              // [RULE_19]
        end
    end

    // Pulse group sequencer: slot counter of pulse-length slots
    logic [31:0] slot_cnt;
    logic [4:0]  slot;
    logic [2:0]  held_code;
    logic        red_pulse;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            slot_cnt  <= '0;
            slot      <= '0;
            held_code <= glk_pkg::CODE_NONE;
        end else if (slot_cnt >= PULSE_CYCLES - 1) begin
            slot_cnt <= '0;
            if (slot >= 5'(2 * held_code + glk_pkg::PAUSE_PULSES) - 5'h1) begin
                slot      <= '0;                                    // [RULE_21]
                held_code <= code;
            end else begin
                slot <= slot + 5'h1;
            end
        end else begin
            slot_cnt <= slot_cnt + 32'h1;
        end
    end
    assign red_pulse = (slot < 5'(2 * held_code)) && !slot[0];      // [RULE_21]

    // Lamps
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            led_green  <= 1'b0;
            led_yellow <= 1'b0;
            led_red    <= 1'b0;
        end else begin
            led_green <= (chain_ok && !inhibit) ? 1'b1 : blink; // [RULE_06] [RULE_07] [RULE_20]
            unique case (guard)
                glk_pkg::GLK_OPEN:   led_yellow <= 1'b0;
                glk_pkg::GLK_CLOSED: led_yellow <= blink;           // [RULE_07]
                glk_pkg::GLK_LOCKED: led_yellow <= 1'b1;
            endcase
            if (!chain_ok) begin
                led_red <= 1'b0;                                    // [RULE_07]
            end else if (s_fi) begin
                led_red <= 1'b1;                                    // [RULE_21]
            end else begin
                led_red <= red_pulse;                               // [RULE_06]
            end
        end
    end

    // Checks
    safe_off_err_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE_09]
        err_now |=> !safe_output_one && !safe_output_two && !diag_out)
        else $error("safety outputs on during error");
    chain_off_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE_07]
        !chain_ok |=> !safe_output_one && !led_red)
        else $error("outputs on without chain input");
    lock_mon_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE_03]
        (!s_pos && guard != glk_pkg::GLK_LOCKED) |=> !safe_output_one)
        else $error("lock variant output on while unlocked");
    pos_mon_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE_05]
        (s_pos && s_closed && chain_ok && !err_now && !inhibit) |=> safe_output_two)
        else $error("position variant output off while closed");
    warn_diag_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE_11]
        (warn_any && !warn_fault && !err_latch && guard == glk_pkg::GLK_LOCKED
         && chain_ok && !inhibit && !s_fa && !s_fk && !s_fi && !s_pos)
        |=> !diag_out && safe_output_one)
        else $error("warning did not split diag and safety");
    sol_ptl_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE_02]
        s_ptl |=> solenoid_lock == $past(s_cmd))
        else $error("power-to-lock decode wrong");
    sol_ptu_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE_01]
        !s_ptl |=> solenoid_lock == !$past(s_cmd))
        else $error("power-to-unlock decode wrong");
    err_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE_10]
        (err_latch && !err_cause && s_closed && !err_seen_open) |=> err_latch)
        else $error("error cleared without guard cycle");
    warn_clr_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE_12]
        !warn_any |=> warn_cnt == 64'h0)
        else $error("warning timer not cleared");
    red_int_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE_21]
        (chain_ok && s_fi) |=> led_red)
        else $error("internal defect not steady red");
    diag_open_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE_08]
        !s_closed |=> !diag_out)
        else $error("diagnostic output high with guard open");
    inhibit_off_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE_20]
        inhibit |=> !safe_output_one && !safe_output_two)
        else $error("safety outputs on during inhibit");
    err_set_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE_18] [RULE_19]
        (s_fa || s_fk || s_fi) |=> err_latch)
        else $error("immediate fault not latched");
    green_on_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE_06]
        (chain_ok && !inhibit) |=> led_green)
        else $error("green lamp off with chain present");

    locked_run_c: cover property (@(posedge clk_sys) disable iff (!resetn)
        safe_output_one && diag_out);
    warn_run_c: cover property (@(posedge clk_sys) disable iff (!resetn)
        safe_output_one && !diag_out);
    err_clear_c: cover property (@(posedge clk_sys) disable iff (!resetn)
        err_latch ##1 !err_latch);
    inhibit_c: cover property (@(posedge clk_sys) disable iff (!resetn)
        inhibit && !led_green);
    code_group_c: cover property (@(posedge clk_sys) disable iff (!resetn)
        held_code == glk_pkg::CODE_KNOB && red_pulse);

endmodule

`default_nettype wire

// file: hdl/glk_pkg.sv
package glk_pkg;

    // Clock rate
    localparam int unsigned CLK_HZ          = 50_000_000;

    // Lamp flash rate and red code timing
    localparam int unsigned FLASH_HZ        = 1;
    localparam int unsigned FLASH_HALF_CYC  = CLK_HZ / (2 * FLASH_HZ);
    localparam int unsigned PULSE_MS        = 200;
    localparam int unsigned PULSE_CYC       = (CLK_HZ / 1000) * PULSE_MS;
    localparam int unsigned PAUSE_PULSES    = 4;

    // Warning escalation and recode inhibit times
    localparam int unsigned WARN_MIN        = 30;
    localparam longint unsigned WARN_CYC    = longint'(CLK_HZ) * 60 * WARN_MIN;
    localparam int unsigned INHIBIT_MIN     = 10;
    localparam longint unsigned INHIBIT_CYC = longint'(CLK_HZ) * 60 * INHIBIT_MIN;

    // Red flash codes
    localparam logic [2:0] CODE_NONE  = 3'h0;
    localparam logic [2:0] CODE_OUT1  = 3'h1;
    localparam logic [2:0] CODE_OUT2  = 3'h2;
    localparam logic [2:0] CODE_CROSS = 3'h3;
    localparam logic [2:0] CODE_TEMP  = 3'h4;
    localparam logic [2:0] CODE_ACT   = 3'h5;
    localparam logic [2:0] CODE_KNOB  = 3'h6;

    typedef enum logic [2:0] {
        GLK_OPEN   = 3'b001,
        GLK_CLOSED = 3'b010,
        GLK_LOCKED = 3'b100
    } glk_guard_e;

endpackage

// file: verif/glk_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none

module glk_ctrl_model (
    input  wire logic clk_sys,
    input  wire logic power_to_lock,
    input  wire logic want_lock,
    input  wire logic safe_output_one,
    input  wire logic safe_output_two,
    output logic      lock_cmd,
    output var logic  run_ok,
    output var logic  split
);
    // Controller turns a lock request into the pin level of the build
    assign lock_cmd = power_to_lock ? want_lock : !want_lock;

    // Monitor runs the machine only while both channels enable
    always_ff @(posedge clk_sys) begin
        run_ok <= safe_output_one & safe_output_two;
        split  <= safe_output_one ^ safe_output_two;
    end
endmodule

`default_nettype wire

// file: verif/glk_guard_lock_tb.sv
`timescale 1ns/1ns
`default_nettype none

module glk_guard_lock_tb;
    localparam int PC = 3;
    logic       clk_sys = 0;
    logic       resetn  = 0;
    logic       ptl = 0, pos = 0, reco = 0, want = 0, cl = 0;
    logic       ch1 = 1, ch2 = 1, gc = 0, al = 0, lp = 0;
    logic [6:0] flt = '0;
    wire logic  lc, sol, so1, so2, dg, lg, ly, lr, run_ok, split;
    int         mismatches  = 0;
    int         check_count = 0;

    glk_guard_lock #(.WARN_CYCLES(200), .INHIBIT_CYCLES(100), .HALF_CYCLES(4),
        .PULSE_CYCLES(PC)) dut (
        .clk_sys(clk_sys), .resetn(resetn), .power_to_lock(ptl), .position_variant(pos),
        .recodable_coding(reco), .one_time_coding(1'b0), .lock_cmd(lc),
        .chain_input_one(ch1), .chain_input_two(ch2), .guard_closed(gc),
        .actuator_locked(al), .lock_possible(lp), .code_learned(cl),
        .fault_out1(flt[0]), .fault_out2(flt[1]), .fault_cross(flt[2]),
        .fault_temp(flt[3]), .fault_actuator(flt[4]), .fault_knob(flt[5]),
        .fault_internal(flt[6]), .solenoid_lock(sol), .safe_output_one(so1),
        .safe_output_two(so2), .diag_out(dg), .led_green(lg), .led_yellow(ly),
        .led_red(lr));

    glk_ctrl_model ctrl (.clk_sys(clk_sys), .power_to_lock(ptl), .want_lock(want),
        .safe_output_one(so1), .safe_output_two(so2), .lock_cmd(lc),
        .run_ok(run_ok), .split(split));

    always #10 clk_sys = ~clk_sys;

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic cmp(input logic got, input logic exp, input string what);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic outs(input logic s, input logic d);
        cmp(so1, s, "safe one");
        cmp(so2, s, "safe two");
        cmp(dg, d, "diag");
        cmp(split, 1'b0, "channels differ");
    endtask

    task automatic guard(input logic c, input logic l);
        gc = c;
        al = l;
        lp = c;
        step(5);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Red pulses in one group, counted once ten low cycles mark the pause
    task automatic red_pulses(input int code);
        int  lows, n, k;
        logic p;
        lows = 0;
        n = 0;
        for (k = 0; k < 400 && !lr; k++) step(1);
        if (!lr) begin
            mismatches++;
            $display("MISMATCH t=%0t red pulses never started", $time);
            test_done();
        end
        for (k = 0; k < 400 && lows < 10; k++) begin
            step(1);
            lows = lr ? 0 : lows + 1;
        end
        if (lows < 10) begin
            mismatches++;
            $display("MISMATCH t=%0t red pause not found", $time);
            test_done();
        end
        for (k = 0; k < (2 * code + 4) * PC; k++) begin
            p = lr;
            step(1);
            if (lr && !p) n++;
        end
        cmp(n == code, 1'b1, $sformatf("pulse count %0d", code));
    endtask

    task automatic t_solenoid;
        for (int p = 0; p < 2; p++) begin
            for (int w = 0; w < 2; w++) begin
                ptl = p[0];
                want = w[0];
                step(5);
                cmp(sol, w[0], "solenoid");
            end
        end
        $display("test solenoid done");
    endtask

    task automatic t_lockmon;
        guard(1, 1);
        outs(1, 1);
        cmp(run_ok, 1'b1, "monitor run");
        cmp(lg, 1'b1, "green");
        cmp(ly, 1'b1, "yellow");
        cmp(lr, 1'b0, "red");
        guard(1, 0);
        outs(0, 1);
        guard(1, 1);
        outs(1, 1);
        pos = 1;
        guard(1, 0);
        outs(1, 1);
        guard(0, 0);
        outs(0, 0);
        pos = 0;
        $display("test monitoring done");
    endtask

    task automatic t_chain;
        logic g0;
        guard(1, 1);
        ch2 = 0;
        step(5);
        outs(0, 1);
        cmp(lr, 1'b0, "red chain");
        cmp(ly, 1'b1, "yellow locked");
        g0 = lg;
        step(4);
        cmp(lg, !g0, "green flash");
        guard(1, 0);
        g0 = ly;
        step(4);
        cmp(ly, !g0, "yellow flash");
        guard(0, 0);
        cmp(ly, 1'b0, "yellow open");
        ch2 = 1;
        guard(1, 1);
        $display("test chain done");
    endtask

    task automatic t_warn;
        flt[3] = 1;
        step(5);
        outs(1, 0);
        flt[3] = 0;
        step(5);
        outs(1, 1);
        flt[3] = 1;
        step(150);
        outs(1, 0);
        step(70);
        outs(0, 0);
        flt[3] = 0;
        step(5);
        outs(0, 0);
        guard(0, 0);
        guard(1, 1);
        outs(1, 1);
        $display("test warning done");
    endtask

    task automatic t_codes;
        logic [6:0] pat [7] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h03};
        int         cd  [7] = '{1, 2, 3, 4, 5, 6, 3};
        for (int i = 0; i < 7; i++) begin
            flt = pat[i];
            step(5);
            outs(cd[i] < 5, 0);
            red_pulses(cd[i]);
            flt = '0;
            guard(0, 0);
            guard(1, 1);
            outs(1, 1);
        end
        flt[6] = 1;
        step(5);
        outs(0, 0);
        for (int i = 0; i < 4; i++) begin
            cmp(lr, 1'b1, "steady red");
            step(5);
        end
        flt = '0;
        guard(0, 0);
        guard(1, 1);
        outs(1, 1);
        $display("test codes done");
    endtask

    task automatic t_inhibit;
        logic g0;
        reco = 1;
        cl = 1;
        step(1);
        cl = 0;
        step(5);
        outs(0, 0);
        g0 = lg;
        step(4);
        cmp(lg, !g0, "green inhibit");
        step(120);
        outs(1, 1);
        $display("test inhibit done");
    endtask

    initial begin
        step(5);
        outs(0, 0);
        cmp(lg, 1'b0, "green in reset");
        step(1);
        resetn = 1;
        t_solenoid();
        t_lockmon();
        t_chain();
        t_warn();
        t_codes();
        t_inhibit();
        test_done();
    end
endmodule

`default_nettype wire
